/* File: spi_cmd_pkg.sv */
// spi_cmd_pkg: types shared by the opcode decoder and its neighbours.
// assumes: nothing beyond the synthesizable subset.
`default_nettype none
package spi_cmd_pkg;

  // status register layout, msb first
  typedef struct packed {
    logic protect_pin_enable;
    logic serial_lock_flag;
    logic [1:0] unused;
    logic block_protect_high;
    logic block_protect_low;
    logic write_latch;
    logic busy;
  } status_t;

  // decoded operation
  typedef enum logic [3:0] {
    cmd_none,
    status_read_cmd,
    status_write_cmd,
    write_latch_set_cmd,
    write_latch_clear_cmd,
    mem_read_cmd,
    mem_write_cmd,
    soft_store_cmd,
    soft_recall_cmd,
    auto_save_on_cmd,
    auto_save_off_cmd,
    sleep_cmd,
    serial_number_write_cmd,
    serial_number_read_cmd,
    identity_read_cmd,
    cmd_invalid
  } cmd_t;

  // one-cycle strobes to the engines at frame end
  typedef struct packed {
    logic mem_write_done;
    logic store;
    logic recall;
    logic auto_save_on;
    logic auto_save_off;
    logic sleep;
    logic sn_write;
  } cmd_strobe_t;

endpackage : spi_cmd_pkg
`default_nettype wire

/* File: spi_cmd_regs.svh */
// spi_cmd_regs.svh: opcode encodings, status bit positions, reset values
// and link bit counts for the spi opcode decoder.
// assumes: included by bare name, definitions only.
`ifndef SPI_CMD_REGS_SVH
`define SPI_CMD_REGS_SVH

// opcode encodings
`define STATUS_READ_CMD 8'h05
`define STATUS_WRITE_CMD 8'h01
`define WRITE_LATCH_SET_CMD 8'h06
`define WRITE_LATCH_CLEAR_CMD 8'h04
`define MEM_READ_CMD 8'h03
`define MEM_WRITE_CMD 8'h02
`define SOFT_STORE_CMD 8'h3C
`define SOFT_RECALL_CMD 8'h60
`define AUTO_SAVE_ON_CMD 8'h59
`define AUTO_SAVE_OFF_CMD 8'h19
`define SLEEP_CMD 8'hB9
`define SERIAL_NUMBER_WRITE_CMD 8'hC2
`define SERIAL_NUMBER_READ_CMD 8'hC3
`define IDENTITY_READ_CMD 8'h9F

// status register bit positions
`define SR_BUSY_BIT 0
`define SR_LATCH_BIT 1
`define SR_BP_LOW_BIT 2
`define SR_BP_HIGH_BIT 3
`define SR_LOCK_BIT 6
`define SR_PIN_EN_BIT 7

// reset / shipped value and the bits a status write may change
`define SR_RESET_VAL 8'h00
`define SR_WRITE_MASK 8'hCC

// block protect lower bounds (13-bit array address)
`define PROT_QUARTER_BASE 13'h1800
`define PROT_HALF_BASE 13'h1000

// link bit counts (value of the bit counter before the edge)
`define OPCODE_LAST_BIT 5'h07
`define SR_DATA_LAST_BIT 5'h0F
`define OUT_FIRST_COUNT 5'h08

`endif

/* File: spi_decode_checker_properties.sv */
// checker for the opcode decoder: watches only the top module pins.
// assumes: link pins stay quiet while reset is low.
`default_nettype none
module spi_decode_checker (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // reset, active low
  input wire logic sck_i, // link clock
  input wire logic cs_n_i, // select, active low
  input wire logic si_i, // serial in
  input wire logic so_o, // serial out
  input wire logic so_oe_o, // serial out enable
  input wire logic wp_n_i, // protect pin
  input wire logic store_busy_i, // store running
  input wire logic recall_busy_i, // recall running
  input wire logic [7:0] nv_sr_i, // stored image in
  input wire logic [12:0] addr_i, // address probe
  input wire spi_cmd_pkg::cmd_strobe_t cmd_o, // frame-end strobes
  input wire spi_cmd_pkg::status_t status_o, // live status
  input wire logic [1:0] prot_level_o, // protect level
  input wire logic prot_hit_o, // protect hit
  input wire logic [7:0] nv_sr_o // image to store
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] up_q; // cycles since reset release, saturating
  logic [4:0] edges_q; // rising link edges in this frame
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // keeps the stored-bit load after reset out of the write check
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end

  // link edge count, cleared by deselect like the design's own counter
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      edges_q <= 5'h00;
    else if (edges_q != 5'h1F)
      edges_q <= edges_q + 5'h01;
  end

  function automatic logic hit_f(input logic [1:0] lv, input logic [12:0] a);
    case (lv)
      2'h0: hit_f = 1'b0;
      2'h1: hit_f = a >= 13'h1800;
      2'h2: hit_f = a >= 13'h1000;
      default: hit_f = 1'b1;
    endcase
  endfunction : hit_f

  sequence s_busy_held;
    (store_busy_i || recall_busy_i) [*3];
  endsequence
  sequence s_idle_held;
    (!store_busy_i && !recall_busy_i) [*3];
  endsequence

  a_oe_deselect: assert property (cs_n_i |-> !so_oe_o)
    else $error("so enabled while deselected");
  a_oe_after_opcode: assert property (@(posedge sck_i) disable iff (cs_n_i || !nrst_i)
    so_oe_o |-> edges_q >= 5'h08)
    else $error("so enabled before the opcode ended");
  a_unused_zero: assert property (status_o.unused == 2'h0)
    else $error("unused status bits not zero");
  a_image_masked: assert property ((nv_sr_o & 8'h33) == 8'h00)
    else $error("stored image carries volatile bits");
  a_busy_set: assert property (s_busy_held |-> status_o.busy)
    else $error("busy low during store or recall");
  a_busy_clear: assert property (s_idle_held |-> !status_o.busy)
    else $error("busy high while idle");
  a_strobe_single: assert property (cmd_o != 7'h00 |-> $onehot(cmd_o) ##1 cmd_o == 7'h00)
    else $error("strobe not a single one-cycle pulse");
  a_lock_sticky: assert property ($past(status_o.serial_lock_flag) |->
    status_o.serial_lock_flag)
    else $error("serial lock returned to zero");
  a_sr_write_gated: assert property (up_q == 2'h3 &&
    (status_o & 8'hCC) != ($past(status_o) & 8'hCC) |-> $past(status_o.write_latch))
    else $error("status bits changed without write latch");
  a_latch_after_frame: assert property ($rose(status_o.write_latch) |-> $past(cs_n_i, 3))
    else $error("write latch set inside a frame");
  a_hit_level: assert property (prot_level_o == $past(prot_level_o) &&
    prot_level_o == $past(prot_level_o, 2) && addr_i == $past(addr_i)
    |-> prot_hit_o == hit_f(prot_level_o, addr_i))
    else $error("protect hit wrong for level");
endmodule : spi_decode_checker

bind spi_opcode_decode_status_reg spi_decode_checker i_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .wp_n_i(wp_n_i), .store_busy_i(store_busy_i), .recall_busy_i(recall_busy_i),
  .nv_sr_i(nv_sr_i), .addr_i(addr_i), .cmd_o(cmd_o), .status_o(status_o),
  .prot_level_o(prot_level_o), .prot_hit_o(prot_hit_o), .nv_sr_o(nv_sr_o));
`default_nettype wire

/* File: spi_master_model.sv */
// spi master model: mode 0 frames, msb first, link clock 30 ns.
// assumes: the caller lets one frame task return before the next.
`default_nettype none
module spi_master_model (
  output logic sck_o, // link clock, still outside frames
  output logic cs_n_o, // select, active low
  output logic si_o, // serial data to the device
  input wire logic so_i, // serial data from the device
  input wire logic so_oe_i // device drives so_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: deselected, clock low for mode 0
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // one frame, bits from tx[31] down; 1 ns offset keeps edges off clk_i
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      output logic [7:0] rx, output logic oe_seen);
    rx = 8'h00;
    oe_seen = 1'b0;
    #1ns;
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      si_o = tx[31 - i];
      #15ns;
      sck_o = 1'b1;
      oe_seen |= so_oe_i;
      if (so_oe_i)
        rx = {rx[6:0], so_i};
      #15ns;
      sck_o = 1'b0;
    end
    #15ns;
    cs_n_o = 1'b1;
    si_o = ~si_o; // no pull on si, so the released line flips
    #90ns;
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

/* File: spi_opcode_decode_status_reg.sv */
// spi_opcode_decode_status_reg: serial opcode capture and decode, status
// register with write latch, block protect, serial lock, protect pin enable.
// assumes: spi master in mode 0 or 3; sck_i still while cs_n_i is high;
// store/recall engines, memory path and wp pin logic on clk_i or pins.
`include "spi_cmd_regs.svh"
`default_nettype none
module spi_opcode_decode_status_reg (
  input wire logic clk_i, // system clock, 200 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic sck_i, // serial clock from master
  input wire logic cs_n_i, // chip select, active low
  input wire logic si_i, // serial data in
  output logic so_o, // serial data out
  output logic so_oe_o, // so output enable, high drives
  input wire logic wp_n_i, // write protect pin, active low
  input wire logic store_busy_i, // store cycle running
  input wire logic recall_busy_i, // recall cycle running
  input wire logic [7:0] nv_sr_i, // stored status image
  input wire logic [12:0] addr_i, // array address to check
  output var spi_cmd_pkg::cmd_strobe_t cmd_o, // frame-end strobes
  output var spi_cmd_pkg::status_t status_o, // live status
  output logic [1:0] prot_level_o, // block protect level
  output logic prot_hit_o, // addr_i is protected
  output logic [7:0] nv_sr_o // image to store
);

  // opcode to operation; reserved and unknown codes are invalid
  function automatic spi_cmd_pkg::cmd_t decode_op(input logic [7:0] op);
    spi_cmd_pkg::cmd_t c;
    c = spi_cmd_pkg::cmd_invalid;
    unique case (op)
      `STATUS_READ_CMD: c = spi_cmd_pkg::status_read_cmd;
      `STATUS_WRITE_CMD: c = spi_cmd_pkg::status_write_cmd;
      `WRITE_LATCH_SET_CMD: c = spi_cmd_pkg::write_latch_set_cmd;
      `WRITE_LATCH_CLEAR_CMD: c = spi_cmd_pkg::write_latch_clear_cmd;
      `MEM_READ_CMD: c = spi_cmd_pkg::mem_read_cmd;
      `MEM_WRITE_CMD: c = spi_cmd_pkg::mem_write_cmd;
      `SOFT_STORE_CMD: c = spi_cmd_pkg::soft_store_cmd;
      `SOFT_RECALL_CMD: c = spi_cmd_pkg::soft_recall_cmd;
      `AUTO_SAVE_ON_CMD: c = spi_cmd_pkg::auto_save_on_cmd;
      `AUTO_SAVE_OFF_CMD: c = spi_cmd_pkg::auto_save_off_cmd;
      `SLEEP_CMD: c = spi_cmd_pkg::sleep_cmd;
      `SERIAL_NUMBER_WRITE_CMD: c = spi_cmd_pkg::serial_number_write_cmd;
      `SERIAL_NUMBER_READ_CMD: c = spi_cmd_pkg::serial_number_read_cmd;
      `IDENTITY_READ_CMD: c = spi_cmd_pkg::identity_read_cmd;
      default: c = spi_cmd_pkg::cmd_invalid;
    endcase
    return c;
  endfunction : decode_op

  // operations that need the write latch and clear it when done
  function automatic logic needs_latch(input spi_cmd_pkg::cmd_t c);
    logic r;
    r = 1'b0;
    unique case (c)
      spi_cmd_pkg::status_write_cmd,
      spi_cmd_pkg::mem_write_cmd,
      spi_cmd_pkg::soft_store_cmd,
      spi_cmd_pkg::soft_recall_cmd,
      spi_cmd_pkg::auto_save_on_cmd,
      spi_cmd_pkg::auto_save_off_cmd,
      spi_cmd_pkg::serial_number_write_cmd: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : needs_latch

  // link side: deselect resets only the bit counter and so outputs; the other link registers hold
  logic link_rst_n;
  logic [4:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] byte_in;
  logic frame_tgl_q;
  logic opc_ok_q;
  logic [7:0] opcode_q;
  logic wr_full_q;
  logic [7:0] wr_data_q;

  // clock domain side
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic wp_meta_q;
  logic wp_sync_q;
  logic wp_frame_q;
  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_seen_q;
  logic cs_rise;
  logic frame_end;
  spi_cmd_pkg::cmd_t cur_cmd;
  logic latch_ok;
  logic hw_lock;
  logic load_pend_q;
  logic store_prev_q;
  logic busy_q;
  logic latch_q;
  logic [1:0] bp_q;
  logic lock_q;
  logic pin_en_q;
  spi_cmd_pkg::status_t cur_sr;
  logic [7:0] shadow_q;
  spi_cmd_pkg::cmd_strobe_t cmd_d;

  assign link_rst_n = nrst_i & ~cs_n_i;
  assign byte_in = {shift_q, si_i};

  // bit counter; once in 16..31 it wraps within that range so status reads can repeat
  always_ff @(posedge sck_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_q <= 5'h00;
    end
    else if (bit_cnt_q[4])
    begin
      bit_cnt_q <= {1'b1, bit_cnt_q[3:0] + 4'h1};
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // msb-first input shifter, sampled on rising sck
  always_ff @(posedge sck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shift_q <= 7'h00;
    end
    else
    begin
      shift_q <= byte_in[6:0];
    end
  end

  // frame marker: flips on the first edge of each frame, so an empty
  // select pulse never replays the previous frame's opcode
  always_ff @(posedge sck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      frame_tgl_q <= 1'b0;
    end
    else if (bit_cnt_q == 5'h00)
    begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // opcode register; held past deselect for the clk side to read
  always_ff @(posedge sck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      opcode_q <= 8'h00;
      opc_ok_q <= 1'b0;
    end
    else if (bit_cnt_q == 5'h00)
    begin
      opc_ok_q <= 1'b0;
    end
    else if (bit_cnt_q == `OPCODE_LAST_BIT)
    begin
      opcode_q <= byte_in;
      opc_ok_q <= 1'b1;
    end
  end

  // status write data: only the first byte after the opcode counts,
  // later bytes and other opcodes leave it alone
  always_ff @(posedge sck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_data_q <= 8'h00;
      wr_full_q <= 1'b0;
    end
    else if (bit_cnt_q == 5'h00)
    begin
      wr_full_q <= 1'b0;
    end
    else if (bit_cnt_q == `SR_DATA_LAST_BIT && opcode_q == `STATUS_WRITE_CMD)
    begin
      wr_data_q <= byte_in;
      wr_full_q <= 1'b1;
    end
  end

  // status out on falling sck; off for every other opcode
  always_ff @(negedge sck_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end
    else if (bit_cnt_q >= `OUT_FIRST_COUNT && opcode_q == `STATUS_READ_CMD)
    begin
      so_oe_o <= 1'b1;
      so_o <= shadow_q[3'h7 - bit_cnt_q[2:0]];
    end
    else
    begin
      so_oe_o <= 1'b0;
      so_o <= 1'b0;
    end
  end

  // pin and toggle synchronisers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
    end
    else
    begin
      cs_meta_q <= cs_n_i;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      wp_meta_q <= wp_n_i;
      wp_sync_q <= wp_meta_q;
      tgl_meta_q <= frame_tgl_q;
      tgl_sync_q <= tgl_meta_q;
    end
  end

  // frame end: select went high after a frame with clock edges; the
  // link registers have been still since the last sck edge
  assign cs_rise = cs_sync_q & ~cs_prev_q;
  assign frame_end = cs_rise & (tgl_sync_q != tgl_seen_q);
  assign cur_cmd = opc_ok_q ? decode_op(opcode_q) : spi_cmd_pkg::cmd_none;
  assign latch_ok = latch_q & needs_latch(cur_cmd);
  assign hw_lock = pin_en_q & ~wp_frame_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tgl_seen_q <= 1'b0;
    end
    else if (cs_rise)
    begin
      tgl_seen_q <= tgl_sync_q;
    end
  end

  // pin level as seen at select; a later drop cannot stop the write
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_frame_q <= 1'b1;
    end
    else if (cs_sync_q)
    begin
      wp_frame_q <= wp_sync_q;
    end
  end

  // busy bit, read only
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= store_busy_i | recall_busy_i;
    end
  end

  // write latch: set or clear at frame end, cleared after write commands
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      latch_q <= 1'b0;
    end
    else if (frame_end)
    begin
      if (cur_cmd == spi_cmd_pkg::write_latch_set_cmd)
      begin
        latch_q <= 1'b1;
      end
      else if (cur_cmd == spi_cmd_pkg::write_latch_clear_cmd)
      begin
        latch_q <= 1'b0;
      end
      else if (needs_latch(cur_cmd))
      begin
        latch_q <= 1'b0;
      end
    end
  end

  // stored bits: loaded from the image once after reset, then changed
  // only by a complete, enabled, unblocked status write
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      load_pend_q <= 1'b1;
      bp_q <= 2'b00;
      lock_q <= 1'b0;
      pin_en_q <= 1'b0;
    end
    else if (load_pend_q)
    begin
      load_pend_q <= 1'b0;
      bp_q <= {nv_sr_i[`SR_BP_HIGH_BIT], nv_sr_i[`SR_BP_LOW_BIT]};
      lock_q <= nv_sr_i[`SR_LOCK_BIT];
      pin_en_q <= nv_sr_i[`SR_PIN_EN_BIT];
    end
    else if (frame_end && cur_cmd == spi_cmd_pkg::status_write_cmd &&
             latch_ok && wr_full_q && !hw_lock)
    begin
      bp_q <= {wr_data_q[`SR_BP_HIGH_BIT], wr_data_q[`SR_BP_LOW_BIT]};
      lock_q <= lock_q | wr_data_q[`SR_LOCK_BIT];
      pin_en_q <= wr_data_q[`SR_PIN_EN_BIT];
    end
  end

  // assembled status; unused bits are constant zero
  always_comb
  begin
    cur_sr = spi_cmd_pkg::status_t'(`SR_RESET_VAL);
    cur_sr.protect_pin_enable = pin_en_q;
    cur_sr.serial_lock_flag = lock_q;
    cur_sr.unused = 2'b00;
    cur_sr.block_protect_high = bp_q[1];
    cur_sr.block_protect_low = bp_q[0];
    cur_sr.write_latch = latch_q;
    cur_sr.busy = busy_q;
  end

  // shadow for the link, frozen while selected so a read is coherent;
  // busy therefore updates only between frames
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shadow_q <= `SR_RESET_VAL;
      status_o <= spi_cmd_pkg::status_t'(`SR_RESET_VAL);
    end
    else
    begin
      status_o <= cur_sr;
      if (cs_sync_q)
      begin
        shadow_q <= cur_sr;
      end
    end
  end

  // frame-end strobes; write-type commands need the latch
  always_comb
  begin
    cmd_d = '0;
    if (frame_end && latch_ok)
    begin
      cmd_d.mem_write_done = (cur_cmd == spi_cmd_pkg::mem_write_cmd);
      cmd_d.store = (cur_cmd == spi_cmd_pkg::soft_store_cmd);
      cmd_d.recall = (cur_cmd == spi_cmd_pkg::soft_recall_cmd);
      cmd_d.auto_save_on = (cur_cmd == spi_cmd_pkg::auto_save_on_cmd);
      cmd_d.auto_save_off = (cur_cmd == spi_cmd_pkg::auto_save_off_cmd);
      cmd_d.sn_write = (cur_cmd == spi_cmd_pkg::serial_number_write_cmd) & ~lock_q;
    end
    if (frame_end)
    begin
      cmd_d.sleep = (cur_cmd == spi_cmd_pkg::sleep_cmd);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmd_o <= '0;
    end
    else
    begin
      cmd_o <= cmd_d;
    end
  end

  // image for storage, taken as a store cycle starts
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      store_prev_q <= 1'b0;
      nv_sr_o <= `SR_RESET_VAL;
    end
    else
    begin
      store_prev_q <= store_busy_i;
      if (load_pend_q)
      begin
        nv_sr_o <= nv_sr_i & `SR_WRITE_MASK;
      end
      else if (store_busy_i && !store_prev_q)
      begin
        nv_sr_o <= cur_sr & `SR_WRITE_MASK;
      end
    end
  end

  // block protect level and address check
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prot_level_o <= 2'b00;
      prot_hit_o <= 1'b0;
    end
    else
    begin
      prot_level_o <= bp_q;
      unique case (bp_q)
        2'b00: prot_hit_o <= 1'b0;
        2'b01: prot_hit_o <= (addr_i >= `PROT_QUARTER_BASE);
        2'b10: prot_hit_o <= (addr_i >= `PROT_HALF_BASE);
        2'b11: prot_hit_o <= 1'b1;
      endcase
    end
  end

endmodule : spi_opcode_decode_status_reg
`default_nettype wire

/* File: spi_opcode_decode_status_reg_bench.sv */
// self-checking bench for the opcode decoder, driven by a master model.
// assumes: checker bound from its own file; clk_i runs at 200 MHz.
`default_nettype none
module spi_opcode_decode_status_reg_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] opc; // opcode sent
    logic pre; // latch set before, else cleared
    logic [6:0] stb; // strobes expected
    logic latch; // latch expected afterwards
  } row_t;
  localparam row_t rows_c [20] = '{
    '{8'h02, 1'h1, 7'h40, 1'h0}, '{8'h3C, 1'h1, 7'h20, 1'h0}, '{8'h60, 1'h1, 7'h10, 1'h0},
    '{8'h59, 1'h1, 7'h08, 1'h0}, '{8'h19, 1'h1, 7'h04, 1'h0}, '{8'hB9, 1'h0, 7'h02, 1'h0},
    '{8'hC2, 1'h1, 7'h01, 1'h0}, '{8'h03, 1'h1, 7'h00, 1'h1}, '{8'hC3, 1'h1, 7'h00, 1'h1},
    '{8'h9F, 1'h1, 7'h00, 1'h1}, '{8'h06, 1'h0, 7'h00, 1'h1}, '{8'h04, 1'h1, 7'h00, 1'h0},
    '{8'h02, 1'h0, 7'h00, 1'h0}, '{8'h3C, 1'h0, 7'h00, 1'h0}, '{8'hC2, 1'h0, 7'h00, 1'h0},
    '{8'h1E, 1'h1, 7'h00, 1'h1}, '{8'h09, 1'h1, 7'h00, 1'h1}, '{8'h0B, 1'h1, 7'h00, 1'h1},
    '{8'hC9, 1'h1, 7'h00, 1'h1}, '{8'h99, 1'h1, 7'h00, 1'h1}};
  logic clk, nrst, sck, cs_n, si, so, so_oe, wp_n, st_busy, rc_busy, hit, oe_seen;
  logic [7:0] nv_in, nv_out, rx;
  logic [12:0] addr;
  logic [1:0] lvl;
  spi_cmd_pkg::cmd_strobe_t cmd, acc;
  spi_cmd_pkg::status_t st;
  int failures = 0;
  int cmp_count = 0;

  spi_master_model i_master (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
    .so_oe_i(so_oe));
  spi_opcode_decode_status_reg i_dut (.clk_i(clk), .nrst_i(nrst), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n),
    .store_busy_i(st_busy), .recall_busy_i(rc_busy), .nv_sr_i(nv_in), .addr_i(addr),
    .cmd_o(cmd), .status_o(st), .prot_level_o(lvl), .prot_hit_o(hit), .nv_sr_o(nv_out));

  // 5 ns system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // strobes are one cycle wide, so gather them between frames
  always @(posedge clk)
    acc = acc | cmd;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic send(input logic [31:0] tx, input int n);
    i_master.xfer(tx, n, rx, oe_seen);
    @(negedge clk);
  endtask : send

  task automatic wsr(input logic [7:0] v);
    send(32'h06000000, 8);
    send({8'h01, v, 16'h0000}, 16);
  endtask : wsr

  task automatic probe(input logic [12:0] a, input logic e);
    addr = a;
    repeat (2) @(negedge clk);
    chk({7'h00, hit}, {7'h00, e});
  endtask : probe

  // hang guard, well past the expected run length
  initial
  begin
    #400us;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    nrst = 1'b0;
    wp_n = 1'b1;
    st_busy = 1'b0;
    rc_busy = 1'b0;
    nv_in = 8'h00;
    addr = 13'h0000;
    acc = '0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk(st, 8'h00);
    send(32'h05000000, 16);
    chk(rx, 8'h00);
    chk({7'h00, oe_seen}, 8'h01);
    // one frame per row, latch forced first; only the status read may drive so
    foreach (rows_c[i])
    begin
      send({rows_c[i].pre ? 8'h06 : 8'h04, 24'h000000}, 8);
      acc = '0;
      send({rows_c[i].opc, 24'h000000}, rows_c[i].opc[7:1] == 7'h61 ? 32 : 8);
      chk({1'h0, acc}, {1'h0, rows_c[i].stb});
      chk({7'h00, st.write_latch}, {7'h00, rows_c[i].latch});
      chk({7'h00, oe_seen}, 8'h00);
    end
    // protect levels, with the masked bits written as ones
    for (int l = 0; l < 4; l++)
    begin
      wsr({4'h3, l[1:0], 2'h3});
      chk(st, {4'h0, l[1:0], 2'h0});
      chk({6'h00, lvl}, {6'h00, l[1:0]});
      send(32'h05000000, 16);
      chk(rx, {4'h0, l[1:0], 2'h0});
      probe(13'h0FFF, l == 3);
      probe(13'h1000, l >= 2);
      probe(13'h17FF, l >= 2);
      probe(13'h1800, l >= 1);
    end
    // short data byte, then a write with no latch
    send(32'h06000000, 8);
    send(32'h01000000, 12);
    chk(st, 8'h0C);
    send(32'h01000000, 16);
    chk(st, 8'h0C);
    // protect pin ignored until enabled, then blocks status writes
    wp_n = 1'b0;
    wsr(8'h8C);
    chk(st, 8'h8C);
    wsr(8'h00);
    chk(st, 8'h8C);
    wp_n = 1'b1;
    wsr(8'h04);
    chk(st, 8'h04);
    // busy follows store and recall; image captured at store start
    st_busy = 1'b1;
    repeat (6) @(negedge clk);
    chk(st, 8'h05);
    chk(nv_out, 8'h04);
    send(32'h05000000, 16);
    chk(rx, 8'h05);
    st_busy = 1'b0;
    rc_busy = 1'b1;
    repeat (6) @(negedge clk);
    chk(st, 8'h05);
    rc_busy = 1'b0;
    repeat (6) @(negedge clk);
    chk(st, 8'h04);
    // lock: serial writes refused, lock cannot be cleared
    wsr(8'h40);
    chk(st, 8'h40);
    send(32'h06000000, 8);
    acc = '0;
    send(32'hC2000000, 32);
    chk({1'h0, acc}, 8'h00);
    chk(st, 8'h40);
    wsr(8'h00);
    chk(st, 8'h40);
    // second reset with a full stored image and the latch set
    send(32'h06000000, 8);
    nv_in = 8'hFF;
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    chk(st, 8'hCC);
    chk({6'h00, lvl}, 8'h03);
    chk(nv_out, 8'hCC);
    tally_and_finish();
  end
endmodule : spi_opcode_decode_status_reg_bench
`default_nettype wire
